// File: fta_cfg.svh
// Constants for the fan tach, PWM and alarm logic.
// Assumes a 250 MHz clock; included by the design files by bare name.
//
// What this block does
// - Count equals 1.35e6 over RPM times divisor
// - One readable count register per tach channel
// - Fan 1/2 divisors reset to 2, field bits 7:4; fan 3 divisor resets to 1
// - Three-bit select gives divisor 1 to 128
// - Two PWM outputs, each 8-bit duty register
// - Duty is value over 255; reset FFh
// - Separate register selects PWM base clock
// - Voltage alarms use two-times mode
// - Fan alarms use two-times mode
// - Hysteresis 127 selects sensor-1 comparator mode
// - Sensor-1 comparator repeats each conversion above limit
// - Sensor-1 two-times: rise and fall below hysteresis
// - Sensor-1 one-time: interrupt only on rising
// - Sensor-2 mode chosen by property bit 6
// - Sensor-2 comparator repeats while above hysteresis
// - Sensor-2 defaults to two-times mode
// - Over-temp output follows sensor 2 only
`ifndef FTA_CFG_SVH
`define FTA_CFG_SVH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define FTA_CLK_MHZ 250
// Count reference rate: 1.35e6 counts per minute of fan time
`define FTA_REF_HZ 22500
// Cycles per count tick, rounded down; stays inside 32-bit arithmetic
`define FTA_TICK_CYC ((`FTA_CLK_MHZ * 1000000) / `FTA_REF_HZ)

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define FTA_DIV_LSB 4
`define FTA_DIV_MSB 7
`define FTA_DIVEXT_LSB 5
`define FTA_DIVEXT_MSB 7
`define FTA_DIV_RESET 8'h50
`define FTA_DUTY_RESET 8'hff
`define FTA_DUTY_FULL 8'hff
`define FTA_PWMCLK_RESET 8'h01
`define FTA_PROP_S2_MODE 6
`define FTA_PROP_RESET 8'h00
`define FTA_HYST_CMP 8'h7f
`define FTA_COUNT_MAX 8'hff
`define FTA_NUM_VOLT 7
`define FTA_NUM_FAN 3

`endif

// File: fta_pkg.sv
// Types shared by the fan tach, PWM and alarm logic.
// Assumes nothing beyond the constants header.
package fta_pkg;
  typedef enum logic [2:0] {
    FTA_MODE_CMP = 3'b001,
    FTA_MODE_TWO = 3'b010,
    FTA_MODE_ONE = 3'b100
  } fta_mode_t;
endpackage : fta_pkg

// File: fta_pwm_if.sv
// Carrier between the top and each PWM channel.
// Assumes one clock domain shared by both ends.
`timescale 1ns/10ps
interface fta_pwm_if;
  logic [7:0] duty;
  logic step;
  logic pwm;
  modport top (output duty, output step, input pwm);
  modport chan (input duty, input step, output pwm);
endinterface : fta_pwm_if

// File: fta_pwm_chan.sv
// One PWM channel: 255-step period, high for duty steps.
// Assumes a step pulse from the shared base clock divider.
`timescale 1ns/10ps
`include "fta_cfg.svh"
module fta_pwm_chan
  import fta_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  fta_pwm_if.chan pif
);
  logic [7:0] phase;

  // Phase runs 0..254 so the period is exactly 255 steps
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      phase <= 8'h00;
    end else if (pif.step) begin
      phase <= (phase == 8'hfe) ? 8'h00 : phase + 8'h01;
    end
  end

  // High while phase below duty; FFh stays high throughout
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pif.pwm <= 1'b1;
    end else begin
      pif.pwm <= (phase < pif.duty);
    end
  end

  a_pwm_full_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pif.duty == `FTA_DUTY_FULL) [*2] |-> pif.pwm)
    else $error("pwm low at full duty");
  a_pwm_zero_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pif.duty == 8'h00) [*2] |-> !pif.pwm)
    else $error("pwm high at zero duty");
  c_pwm_mid: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    pif.pwm ##1 !pif.pwm);
endmodule : fta_pwm_chan

// File: fta_top.sv
// Fan tach counters, two PWM outputs and the management alarm logic.
// Assumes synchronous inputs; ADC readings arrive with a conversion-done
// pulse, and status reads arrive as one-cycle pulses.
`timescale 1ns/10ps
`include "fta_cfg.svh"
module fta_top
  import fta_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] fan_tach_i,
  input wire logic [7:0] fan_divisor_reg_i,
  input wire logic fan_divisor_we_i,
  input wire logic [7:0] divisor_ext_reg_i,
  input wire logic divisor_ext_we_i,
  input wire logic [7:0] pwm1_duty_reg_i,
  input wire logic pwm1_duty_we_i,
  input wire logic [7:0] pwm2_duty_reg_i,
  input wire logic pwm2_duty_we_i,
  input wire logic [7:0] pwm_clk_sel_reg_i,
  input wire logic pwm_clk_sel_we_i,
  input wire logic [7:0] alarm_property_sel_reg_i,
  input wire logic alarm_property_sel_we_i,
  input wire logic conv_done_i,
  input wire logic [55:0] volt_val_i,
  input wire logic [55:0] volt_high_i,
  input wire logic [55:0] volt_low_i,
  input wire logic [23:0] fan_limit_i,
  input wire logic [7:0] temp1_i,
  input wire logic [7:0] temp1_over_i,
  input wire logic [7:0] hyst_limit_i,
  input wire logic temp1_one_time_i,
  input wire logic [7:0] temp2_i,
  input wire logic [7:0] temp2_over_i,
  input wire logic [7:0] temp2_hyst_i,
  input wire logic [12:0] alarm_mask_i,
  input wire logic status_read_all_i,
  input wire logic temp2_read_i,
  output logic [7:0] fan1_count_reg_o,
  output logic [7:0] fan2_count_reg_o,
  output logic [7:0] fan3_count_reg_o,
  output logic [7:0] fan_divisor_reg_o,
  output logic [7:0] divisor_ext_reg_o,
  output logic [7:0] pwm_clk_sel_reg_o,
  output logic [12:0] alarm_status_o,
  output logic pwm1_o,
  output logic pwm2_o,
  output logic mgmt_alarm_irq_o,
  output logic overtemp_out_o
);
  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [7:0] fan_div;
  logic [7:0] div_ext;
  logic [7:0] duty1;
  logic [7:0] duty2;
  logic [7:0] pwm_clk_sel;
  logic [7:0] prop_sel;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fan_div <= `FTA_DIV_RESET;
      div_ext <= 8'h00;
    end else begin
      if (fan_divisor_we_i) fan_div <= fan_divisor_reg_i;
      if (divisor_ext_we_i) div_ext <= divisor_ext_reg_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      duty1 <= `FTA_DUTY_RESET;
      duty2 <= `FTA_DUTY_RESET;
      pwm_clk_sel <= `FTA_PWMCLK_RESET;
      prop_sel <= `FTA_PROP_RESET;
    end else begin
      if (pwm1_duty_we_i) duty1 <= pwm1_duty_reg_i;
      if (pwm2_duty_we_i) duty2 <= pwm2_duty_reg_i;
      if (pwm_clk_sel_we_i) pwm_clk_sel <= pwm_clk_sel_reg_i;
      if (alarm_property_sel_we_i) prop_sel <= alarm_property_sel_reg_i;
    end
  end

  assign fan_divisor_reg_o = fan_div;
  assign divisor_ext_reg_o = div_ext;
  assign pwm_clk_sel_reg_o = pwm_clk_sel;

  // ------------------------------------------------------------
  // Fan counters
  // ------------------------------------------------------------
  // Three select bits per fan: bits 5..7 of the extension word carry the
  // top bit of fan 1..3; fan 1/2 low bits in divisor register bits 5:4 and 7:6,
  // fan 3 low bits taken from the extension word low bits.
  logic [2:0] div_sel [3];
  assign div_sel[0] = {div_ext[`FTA_DIVEXT_LSB], fan_div[5:4]};
  assign div_sel[1] = {div_ext[6], fan_div[`FTA_DIV_MSB:6]};
  assign div_sel[2] = {div_ext[`FTA_DIVEXT_MSB], div_ext[1:0]};

  logic [23:0] tick_cnt;
  logic tick;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || tick) begin
      tick_cnt <= 24'h000000;
    end else begin
      tick_cnt <= tick_cnt + 24'h000001;
    end
  end
  assign tick = (tick_cnt == 24'(`FTA_TICK_CYC - 1));

  logic [2:0] tach_q;
  logic [7:0] run_cnt [3];
  logic [6:0] pre_cnt [3];
  logic [7:0] cnt_out [3];
  logic [1:0] rev_half [3];

  // The count spans two tach periods, in reference ticks divided by divisor,
  // which gives 1.35e6 / (RPM * divisor) for two pulses per revolution.
  for (genvar f = 0; f < `FTA_NUM_FAN; f++) begin : g_fan
    logic rise;
    logic [6:0] div_m1;
    assign rise = fan_tach_i[f] && !tach_q[f];
    assign div_m1 = 7'((8'h01 << div_sel[f]) - 8'h01);

    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        tach_q[f] <= 1'b0;
        run_cnt[f] <= 8'h00;
        pre_cnt[f] <= 7'h00;
        cnt_out[f] <= `FTA_COUNT_MAX;
        rev_half[f] <= 2'h0;
      end else begin
        tach_q[f] <= fan_tach_i[f];
        if (rise) begin
          rev_half[f] <= rev_half[f] + 2'h1;
          if (rev_half[f] == 2'h1) begin
            cnt_out[f] <= run_cnt[f];
            run_cnt[f] <= 8'h00;
            pre_cnt[f] <= 7'h00;
            rev_half[f] <= 2'h0;
          end
        end else if (tick) begin
          // Prescale by divisor; saturate so a stopped fan reads FFh
          if (pre_cnt[f] >= div_m1) begin
            pre_cnt[f] <= 7'h00;
            if (run_cnt[f] != `FTA_COUNT_MAX) run_cnt[f] <= run_cnt[f] + 8'h01;
            else cnt_out[f] <= `FTA_COUNT_MAX;
          end else begin
            pre_cnt[f] <= pre_cnt[f] + 7'h01;
          end
        end
      end
    end
  end

  assign fan1_count_reg_o = cnt_out[0];
  assign fan2_count_reg_o = cnt_out[1];
  assign fan3_count_reg_o = cnt_out[2];

  // ------------------------------------------------------------
  // PWM outputs
  // ------------------------------------------------------------
  logic [7:0] base_div;
  logic pwm_step;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || pwm_step) begin
      base_div <= 8'h00;
    end else begin
      base_div <= base_div + 8'h01;
    end
  end
  assign pwm_step = (base_div >= pwm_clk_sel);

  fta_pwm_if pwm_a ();
  fta_pwm_if pwm_b ();
  assign pwm_a.duty = duty1;
  assign pwm_a.step = pwm_step;
  assign pwm_b.duty = duty2;
  assign pwm_b.step = pwm_step;

  fta_pwm_chan u_pwm1 (.clk_i(clk_i), .rst_n_i(rst_n_i), .pif(pwm_a));
  fta_pwm_chan u_pwm2 (.clk_i(clk_i), .rst_n_i(rst_n_i), .pif(pwm_b));
  assign pwm1_o = pwm_a.pwm;
  assign pwm2_o = pwm_b.pwm;

  // ------------------------------------------------------------
  // Alarm conditions
  // ------------------------------------------------------------
  // Status bits: 0..6 voltage, 7..9 fan, 10 sensor 1, 11 sensor 2,
  // 12 reserved low.
  logic [6:0] v_out;
  logic [2:0] f_out;
  for (genvar v = 0; v < `FTA_NUM_VOLT; v++) begin : g_volt
    assign v_out[v] = (volt_val_i[v*8 +: 8] > volt_high_i[v*8 +: 8]) ||
                      (volt_val_i[v*8 +: 8] < volt_low_i[v*8 +: 8]);
  end
  for (genvar f = 0; f < `FTA_NUM_FAN; f++) begin : g_flim
    assign f_out[f] = cnt_out[f] > fan_limit_i[f*8 +: 8];
  end

  fta_mode_t s1_mode;
  fta_mode_t s2_mode;
  always_comb begin
    if (hyst_limit_i == `FTA_HYST_CMP) s1_mode = FTA_MODE_CMP;
    else if (temp1_one_time_i) s1_mode = FTA_MODE_ONE;
    else s1_mode = FTA_MODE_TWO;
    s2_mode = prop_sel[`FTA_PROP_S2_MODE] ? FTA_MODE_CMP : FTA_MODE_TWO;
  end

  logic t1_over;
  logic t1_under;
  logic t2_over;
  logic t2_under;
  assign t1_over = $signed(temp1_i) > $signed(temp1_over_i);
  assign t1_under = $signed(temp1_i) < $signed(hyst_limit_i);
  assign t2_over = $signed(temp2_i) > $signed(temp2_over_i);
  assign t2_under = $signed(temp2_i) < $signed(temp2_hyst_i);

  // ------------------------------------------------------------
  // Event detection and sticky status
  // ------------------------------------------------------------
  // Each source remembers whether it is out of range (armed). Two-times
  // sources flag on entry and on exit; status sets win over a read clear.
  logic [9:0] vf_out_q;
  logic t1_hot;
  logic t2_hot;
  logic [12:0] status;
  logic [12:0] next_set;

  always_comb begin
    next_set = 13'h0000;
    if (conv_done_i) begin
      next_set[9:0] = {f_out, v_out} ^ vf_out_q;
      unique case (s1_mode)
        FTA_MODE_CMP: next_set[10] = t1_over;
        FTA_MODE_TWO: next_set[10] = (!t1_hot && t1_over) ||
                                     (t1_hot && t1_under);
        FTA_MODE_ONE: next_set[10] = !t1_hot && t1_over;
      endcase
      unique case (s2_mode)
        FTA_MODE_CMP: next_set[11] = t2_over || (t2_hot && !t2_under);
        FTA_MODE_TWO: next_set[11] = (!t2_hot && t2_over) ||
                                     (t2_hot && t2_under);
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      vf_out_q <= 10'h000;
      t1_hot <= 1'b0;
      t2_hot <= 1'b0;
    end else if (conv_done_i) begin
      vf_out_q <= {f_out, v_out};
      if (t1_over) t1_hot <= 1'b1;
      else if (s1_mode == FTA_MODE_CMP || t1_under) t1_hot <= 1'b0;
      if (t2_over) t2_hot <= 1'b1;
      else if (t2_under) t2_hot <= 1'b0;
    end
  end

  // A pending bit stays set, and holds the interrupt while unmasked, until the full status read clears it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status <= 13'h0000;
    end else begin
      status <= (status & ~{13{status_read_all_i}}) | next_set;
    end
  end
  assign alarm_status_o = status;

  assign mgmt_alarm_irq_o = |(status & ~alarm_mask_i);

  // ------------------------------------------------------------
  // Over-temperature output, sensor 2 only
  // ------------------------------------------------------------
  // Comparator behaviour by default: active low while above limit until
  // below hysteresis; a sensor-2 read has no effect in this mode.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      overtemp_out_o <= 1'b1;
    end else if (conv_done_i) begin
      if (t2_over) overtemp_out_o <= 1'b0;
      else if (t2_under) overtemp_out_o <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_irq_read_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (status_read_all_i && !conv_done_i) |=> !mgmt_alarm_irq_o)
    else $error("irq still high after status read");
  a_status_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (status[0] && !status_read_all_i) |=> status[0])
    else $error("voltage status lost without read");
  a_volt_entry_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (conv_done_i && v_out[0] && !vf_out_q[0]) |=> status[0])
    else $error("voltage excursion not flagged");
  a_fan_exit_sets: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (conv_done_i && !f_out[0] && vf_out_q[7]) |=> status[7])
    else $error("fan return not flagged");
  a_s1_cmp_repeat: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (conv_done_i && hyst_limit_i == `FTA_HYST_CMP && t1_over) |=> status[10])
    else $error("sensor1 comparator repeat missing");
  a_s1_one_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (conv_done_i && s1_mode == FTA_MODE_ONE && t1_hot && !status_read_all_i
     && !status[10]) |=> !status[10])
    else $error("one-time mode interrupted twice");
  a_s2_two_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (conv_done_i && s2_mode == FTA_MODE_TWO && t2_hot && !t2_under && !status[11]
     && !status_read_all_i) |=> !status[11])
    else $error("sensor2 two-times fired above hysteresis");
  a_s1_two_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (conv_done_i && s1_mode == FTA_MODE_TWO && t1_hot && t1_under) |=> status[10])
    else $error("sensor1 fall below hysteresis not flagged");
  a_s2_cmp_repeat: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (conv_done_i && s2_mode == FTA_MODE_CMP && t2_over) |=> status[11])
    else $error("sensor2 comparator repeat missing");
  a_s2_cmp_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (conv_done_i && s2_mode == FTA_MODE_CMP && !t2_over && t2_under && !status[11]
     && !status_read_all_i) |=> !status[11])
    else $error("sensor2 comparator fired below hysteresis");
  a_ovt_conv_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !conv_done_i |=> $stable(overtemp_out_o))
    else $error("overtemp moved without a conversion");
  a_ovt_sensor2: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (conv_done_i && t2_over) |=> !overtemp_out_o)
    else $error("overtemp not driven by sensor2");
  a_div_reset: assert property (@(posedge clk_i)
    $rose(rst_n_i) |-> div_sel[0] == 3'h1)
    else $error("divisor not two after reset");
  c_irq_raise: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(mgmt_alarm_irq_o));
  c_read_clear: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    status_read_all_i ##1 !mgmt_alarm_irq_o);
  c_s2_cmp: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    s2_mode == FTA_MODE_CMP && next_set[11]);
  c_s1_one: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    s1_mode == FTA_MODE_ONE && next_set[10]);
endmodule : fta_top

// File: fta_fan_model.sv
// Fan model: three tach outputs and two PWM high-time meters.
// Assumes the bench clock; a running fan gives a square tach wave,
// two rising edges per turn, and a stopped fan holds its tach level.
`timescale 1ns/10ps
module fta_fan_model (
  input wire logic clk_i,
  input wire logic [2:0] run_i,
  input wire logic [15:0] half_i,
  input wire logic pwm1_i,
  input wire logic pwm2_i,
  input wire logic meter_clr_i,
  output logic [2:0] tach_o,
  output logic [15:0] pwm1_high_o,
  output logic [15:0] pwm2_high_o
);
  logic [15:0] phase;

  initial begin
    tach_o = 3'h0;
    phase = 16'h0;
    pwm1_high_o = 16'h0;
    pwm2_high_o = 16'h0;
  end

  // ------------------------------------------------------------
  // Tach generation
  // ------------------------------------------------------------
  // Changes just after the falling edge, like the bench stimulus
  always @(negedge clk_i) begin
    if (phase + 16'h1 >= half_i) begin
      phase <= 16'h0;
      tach_o <= tach_o ^ run_i;
    end else begin
      phase <= phase + 16'h1;
    end
  end

  // ------------------------------------------------------------
  // PWM meters
  // ------------------------------------------------------------
  // Sampled on the rising edge so the clear never races the count
  always @(posedge clk_i) begin
    if (meter_clr_i) begin
      pwm1_high_o <= 16'h0;
      pwm2_high_o <= 16'h0;
    end else begin
      pwm1_high_o <= pwm1_high_o + {15'h0, pwm1_i};
      pwm2_high_o <= pwm2_high_o + {15'h0, pwm2_i};
    end
  end
endmodule : fta_fan_model

// File: fta_top_tb.sv
// Self-checking bench for the fan tach, PWM and alarm logic.
// Assumes the fan model as far side; status reads are one-cycle pulses.
`timescale 1ns/10ps
`include "fta_cfg.svh"
module fta_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] tach, run;
  logic [7:0] div_d, ext_d, d1, d2, pclk_d, prop_d, t1, t1o, hy, t2, t2o, t2h;
  logic div_we, ext_we, d1_we, d2_we, pclk_we, prop_we, conv, rd_all, one_time, mclr;
  logic [55:0] vv, vh, vl;
  logic [23:0] flim;
  logic [12:0] mask, st;
  logic [7:0] c1, c2, c3, div_q, ext_q, pclk_q;
  logic p1, p2, irq, ovt_n;
  logic [15:0] half, h1, h2;
  int err_count = 0;
  int n_tests = 0;

  always #2 clk = ~clk;

  fta_top dut (.clk_i(clk), .rst_n_i(rst_n), .fan_tach_i(tach),
    .fan_divisor_reg_i(div_d), .fan_divisor_we_i(div_we), .divisor_ext_reg_i(ext_d),
    .divisor_ext_we_i(ext_we), .pwm1_duty_reg_i(d1), .pwm1_duty_we_i(d1_we),
    .pwm2_duty_reg_i(d2), .pwm2_duty_we_i(d2_we), .pwm_clk_sel_reg_i(pclk_d),
    .pwm_clk_sel_we_i(pclk_we), .alarm_property_sel_reg_i(prop_d),
    .alarm_property_sel_we_i(prop_we), .conv_done_i(conv), .volt_val_i(vv),
    .volt_high_i(vh), .volt_low_i(vl), .fan_limit_i(flim), .temp1_i(t1),
    .temp1_over_i(t1o), .hyst_limit_i(hy), .temp1_one_time_i(one_time), .temp2_i(t2),
    .temp2_over_i(t2o), .temp2_hyst_i(t2h), .alarm_mask_i(mask),
    .status_read_all_i(rd_all), .temp2_read_i(1'b0), .fan1_count_reg_o(c1),
    .fan2_count_reg_o(c2), .fan3_count_reg_o(c3), .fan_divisor_reg_o(div_q),
    .divisor_ext_reg_o(ext_q), .pwm_clk_sel_reg_o(pclk_q), .alarm_status_o(st),
    .pwm1_o(p1), .pwm2_o(p2), .mgmt_alarm_irq_o(irq), .overtemp_out_o(ovt_n));

  fta_fan_model fans (.clk_i(clk), .run_i(run), .half_i(half), .pwm1_i(p1), .pwm2_i(p2),
    .meter_clr_i(mclr), .tach_o(tach), .pwm1_high_o(h1), .pwm2_high_o(h2));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input int r, input logic [7:0] v);
    @(negedge clk);
    case (r)
      0: begin div_d = v; div_we = 1'b1; end
      1: begin ext_d = v; ext_we = 1'b1; end
      2: begin d1 = v; d1_we = 1'b1; end
      3: begin d2 = v; d2_we = 1'b1; end
      4: begin pclk_d = v; pclk_we = 1'b1; end
      default: begin prop_d = v; prop_we = 1'b1; end
    endcase
    @(negedge clk);
    {div_we, ext_we, d1_we, d2_we, pclk_we, prop_we} = 6'h00;
  endtask : wr

  // One conversion or one status read; status settles before return
  task automatic pulse(input logic c, input logic r);
    @(negedge clk);
    conv = c;
    rd_all = r;
    @(negedge clk);
    conv = 1'b0;
    rd_all = 1'b0;
  endtask : pulse

  task automatic cv(input logic [12:0] exp);
    pulse(1'b1, 1'b0);
    check("alarm_status", {3'h0, st}, {3'h0, exp});
  endtask : cv

  // Duty takes effect on the next clock, even mid-period; settle one period first
  task automatic meter(input logic [7:0] a, input logic [7:0] b, input int e1, input int e2);
    wr(2, a);
    wr(3, b);
    repeat (300) @(negedge clk);
    mclr = 1'b1;
    @(negedge clk);
    mclr = 1'b0;
    repeat (510) @(negedge clk);
    check("pwm1_high", h1, e1[15:0]);
    check("pwm2_high", h2, e2[15:0]);
  endtask : meter

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check("counts", {c1, c2}, 16'hffff);
    check("fan3_count", {8'h0, c3}, 16'h00ff);
    check("divisor", {8'h0, div_q}, {8'h0, `FTA_DIV_RESET});
    check("ext", {8'h0, ext_q}, 16'h0000);
    check("pwm_clk", {8'h0, pclk_q}, {8'h0, `FTA_PWMCLK_RESET});
    check("pwm_out", {14'h0, p1, p2}, 16'h0003);
    check("irq_ovt", {14'h0, irq, ovt_n}, 16'h0001);
  endtask : t_reset

  task automatic t_regs();
    wr(0, 8'ha5);
    check("divisor", {8'h0, div_q}, 16'h00a5);
    wr(1, 8'he0);
    check("ext", {8'h0, ext_q}, 16'h00e0);
    wr(4, 8'h00);
    check("pwm_clk", {8'h0, pclk_q}, 16'h0000);
  endtask : t_regs

  task automatic t_volt();
    vv[7:0] = 8'hc0;
    cv(13'h0001);
    check("irq", {15'h0, irq}, 16'h0001);
    pulse(1'b0, 1'b1);
    check("irq", {15'h0, irq}, 16'h0000);
    cv(13'h0000);
    vv[7:0] = 8'h80;
    mask = 13'h0001;
    cv(13'h0001);
    check("irq_masked", {15'h0, irq}, 16'h0000);
    mask = 13'h0000;
    pulse(1'b0, 1'b1);
    vv[55:48] = 8'h10;
    cv(13'h0040);
    vv[55:48] = 8'h80;
    pulse(1'b0, 1'b1);
    cv(13'h0040);
    pulse(1'b0, 1'b1);
  endtask : t_volt

  task automatic t_fan_alarm();
    flim = 24'h101010;
    cv(13'h0380);
    pulse(1'b0, 1'b1);
    cv(13'h0000);
    flim = 24'hffffff;
    cv(13'h0380);
    pulse(1'b0, 1'b1);
  endtask : t_fan_alarm

  task automatic t_temp1();
    hy = `FTA_HYST_CMP;
    t1 = 8'h50;
    cv(13'h0400);
    cv(13'h0400);
    check("overtemp", {15'h0, ovt_n}, 16'h0001);
    pulse(1'b0, 1'b1);
    cv(13'h0400);
    pulse(1'b0, 1'b1);
    t1 = 8'h00;
    cv(13'h0000);
    hy = 8'h20;
    t1 = 8'h50;
    cv(13'h0400);
    pulse(1'b0, 1'b1);
    t1 = 8'h30;
    cv(13'h0000);
    t1 = 8'h10;
    cv(13'h0400);
    pulse(1'b0, 1'b1);
    one_time = 1'b1;
    t1 = 8'h50;
    cv(13'h0400);
    pulse(1'b0, 1'b1);
    t1 = 8'h10;
    cv(13'h0000);
    t1 = 8'h50;
    cv(13'h0400);
    pulse(1'b0, 1'b1);
  endtask : t_temp1

  task automatic t_temp2();
    t2 = 8'h50;
    cv(13'h0800);
    @(negedge clk);
    check("overtemp", {15'h0, ovt_n}, 16'h0000);
    pulse(1'b0, 1'b1);
    cv(13'h0000);
    t2 = 8'h10;
    cv(13'h0800);
    @(negedge clk);
    check("overtemp", {15'h0, ovt_n}, 16'h0001);
    pulse(1'b0, 1'b1);
    wr(5, 8'h40);
    t2 = 8'h50;
    cv(13'h0800);
    pulse(1'b0, 1'b1);
    t2 = 8'h30;
    cv(13'h0800);
    pulse(1'b0, 1'b1);
    t2 = 8'h10;
    cv(13'h0000);
  endtask : t_temp2

  // One turn is two count ticks: divisor 1 gives about 2, divisor 2 about 1
  task automatic t_fan_count();
    int n;
    wr(0, 8'h40);
    wr(1, 8'h00);
    run = 3'b011;
    n = 0;
    while (c1 === 8'hff && n < 60000) begin
      @(negedge clk);
      n++;
    end
    repeat (22300) @(negedge clk);
    check("fan1_range", {15'h0, c1 >= 8'h01 && c1 <= 8'h03}, 16'h0001);
    check("fan2_range", {15'h0, c2 <= 8'h02}, 16'h0001);
    check("fan3_stalled", {8'h0, c3}, 16'h00ff);
  endtask : t_fan_count

  task automatic close_out();
    $display("err_count=%0d n_tests=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    {div_d, ext_d, d1, d2, pclk_d, prop_d} = {6{8'h00}};
    {div_we, ext_we, d1_we, d2_we, pclk_we, prop_we, conv, rd_all, one_time, mclr} = 10'h0;
    vv = {7{8'h80}};
    vh = {7{8'hb0}};
    vl = {7{8'h40}};
    flim = 24'hffffff;
    {t1, t2, t1o, t2o, hy, t2h} = {16'h0000, 16'h4040, 16'h2020};
    mask = 13'h0000;
    run = 3'b000;
    half = 16'd5555;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_regs();
    meter(8'h80, 8'h40, 256, 128);
    meter(8'h00, 8'hff, 0, 510);
    t_volt();
    t_fan_alarm();
    t_temp1();
    t_temp2();
    t_fan_count();
    close_out();
  end

  // Whole run is about 39k cycles, the fan scenario being most of it
  initial begin
    #240000;
    err_count++;
    close_out();
  end
endmodule : fta_top_tb
